// File: hdl/ast_regs.svh
// Purpose: Register offsets, field positions and timing counts of the serial transmitter
// Assumes: 9-bit register file address, 8-bit data
// Notes:   Included by the package and by the transmitter
`ifndef AST_REGS_SVH
`define AST_REGS_SVH

// Register file offsets
`define AST_OFS_CORE_IRQ_CONTROL     9'h00B
`define AST_OFS_CORE_IRQ_CONTROL_M1  9'h08B
`define AST_OFS_CORE_IRQ_CONTROL_M2  9'h10B
`define AST_OFS_CORE_IRQ_CONTROL_M3  9'h18B
`define AST_OFS_PERIPH_IRQ_FLAGS     9'h00C
`define AST_OFS_RECEIVE_STATUS_CTRL  9'h018
`define AST_OFS_TRANSMIT_HOLDING     9'h019
`define AST_OFS_PERIPH_IRQ_ENABLES   9'h08C
`define AST_OFS_TRANSMIT_STATUS_CTRL 9'h098
`define AST_OFS_BAUD_DIVISOR         9'h099

// Reset values
`define AST_RST_CORE_IRQ_CONTROL     8'h00
`define AST_RST_PERIPH_IRQ_ENABLES   8'h00
`define AST_RST_RECEIVE_STATUS_CTRL  8'h00
`define AST_RST_TRANSMIT_STATUS_CTRL 8'h02
`define AST_RST_BAUD_DIVISOR         8'h00
`define AST_RST_TRANSMIT_HOLDING     8'h00

// Field positions
`define AST_BIT_GLOBAL_IRQ_ENABLE    7
`define AST_BIT_PERIPH_IRQ_ENABLE    6
`define AST_BIT_TRANSMIT_IRQ         4
`define AST_BIT_SERIAL_PORT_ON       7
`define AST_BIT_NINTH_TX_ENABLE      6
`define AST_BIT_TRANSMIT_ENABLE      5
`define AST_BIT_CLOCKED_MODE         4
`define AST_BIT_HIGH_SPEED_SELECT    2
`define AST_BIT_SHIFT_REG_EMPTY      1
`define AST_BIT_NINTH_BIT_VALUE      0
`define AST_MASK_TRANSMIT_STATUS     8'hF5

// Baud generator: oscillator periods per bit are multiplier times (divisor + 1)
`define AST_MULT_NORMAL_LOG2         4'h6
`define AST_MULT_FAST_LOG2           4'h4
`define AST_BITLEN_W                 15

// Frame lengths in bit periods, start and stop included
`define AST_FRAME_BITS_8             4'hA
`define AST_FRAME_BITS_9             4'hB

`endif

// File: hdl/ast_pkg.sv
// Purpose: Shared types and baud arithmetic for the serial transmitter and its receiver
// Assumes: ast_regs.svh on the include path
// Notes:   Both link ends compute bit periods through the same function
`include "ast_regs.svh"

package ast_pkg;

    typedef logic [`AST_BITLEN_W-1:0] ast_bitlen_t;
    typedef logic [8:0]               ast_word_t;

    // Oscillator periods per bit: 64*(div+1) normal, 16*(div+1) high speed
    function automatic ast_bitlen_t ast_bit_len(input logic [7:0] div, input logic fast);
        ast_bitlen_t base;
        base = ast_bitlen_t'({1'b0, div}) + ast_bitlen_t'(1);
        return fast ? ast_bitlen_t'(base << `AST_MULT_FAST_LOG2)
                    : ast_bitlen_t'(base << `AST_MULT_NORMAL_LOG2);
    endfunction

    function automatic logic [3:0] ast_frame_bits(input logic nine);
        return nine ? `AST_FRAME_BITS_9 : `AST_FRAME_BITS_8;
    endfunction

endpackage

// File: hdl/ast_if.sv
// Purpose: Serial line from transmitter to receiver
// Assumes: Both ends on the same oscillator clock
// Notes:   Line idles high
`timescale 1ns/10ps

interface ast_if;
    logic tx_line;

    modport xmit (output tx_line);
    modport recv (input  tx_line);
endinterface

// File: hdl/ast_buf.sv
// Purpose: Small valid/ready buffer between the holding register and the shifter
// Assumes: DEPTH is a power of two
// Notes:   Flush empties it in one cycle
`timescale 1ns/10ps

module ast_buf #(
    parameter int W     = 9,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         sys_rst_i,
    input  wire logic         flush_i,
    // Fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0]   count_r;
    wire           push;
    wire           pop;

    assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || flush_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end
endmodule

// File: hdl/ast_xmit.sv
// Purpose: Asynchronous serial transmitter with its register file
// Assumes: clock_i is the oscillator; strobed register port
// Notes:   Rules listed below
// Function
// RULE1 - Software loads divisor before transmitting
// RULE2 - High-speed select gives faster range
// RULE3 - Normal range: 20 MHz, 129->2404, 32->9470
// RULE4 - Fast range: 20 MHz, 129->9615, 4->250000
// RULE5 - Async needs clocked-mode clear, port on
// RULE6 - Interrupt out only when its enable set
// RULE7 - Ninth-bit enable makes nine data bits
// RULE8 - Software writes ninth bit before data
// RULE9 - Transmit enable also sets interrupt flag
// RULE10 - Holding write starts a frame
// RULE11 - Software sets global and peripheral enables
// RULE12 - Bit period 64 or 16 times divisor+1
// RULE13 - Start low, LSB first, ninth, stop high
`timescale 1ns/10ps
`include "ast_regs.svh"

module ast_xmit (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    // Register file
    input  wire logic [8:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic [7:0]      reg_rdata_o,
    // Interrupt
    output logic            tx_irq_o,
    // Serial line
    ast_if.xmit             link
);
    typedef enum logic {AST_IDLE, AST_SEND} ast_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0]           core_irq_control_r;
    logic [7:0]           periph_irq_enables_r;
    logic [7:0]           receive_status_control_r;
    logic [7:0]           transmit_status_control_r;
    logic [7:0]           baud_divisor_r;
    logic [7:0]           transmit_holding_r;
    logic [7:0]           reg_rdata_r;
    logic                 tx_irq_r;

    ast_state_t           state_r;
    ast_pkg::ast_bitlen_t timer_r;
    logic [10:0]          shift_r;
    logic [3:0]           bits_left_r;
    logic                 line_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode
    wire sel_core  = (reg_addr_i == `AST_OFS_CORE_IRQ_CONTROL)    || (reg_addr_i == `AST_OFS_CORE_IRQ_CONTROL_M1) ||
                     (reg_addr_i == `AST_OFS_CORE_IRQ_CONTROL_M2) || (reg_addr_i == `AST_OFS_CORE_IRQ_CONTROL_M3);
    wire sel_flags = (reg_addr_i == `AST_OFS_PERIPH_IRQ_FLAGS);
    wire sel_rcsc  = (reg_addr_i == `AST_OFS_RECEIVE_STATUS_CTRL);
    wire sel_hold  = (reg_addr_i == `AST_OFS_TRANSMIT_HOLDING);
    wire sel_ien   = (reg_addr_i == `AST_OFS_PERIPH_IRQ_ENABLES);
    wire sel_tsc   = (reg_addr_i == `AST_OFS_TRANSMIT_STATUS_CTRL);
    wire sel_div   = (reg_addr_i == `AST_OFS_BAUD_DIVISOR);

    wire serial_port_on   = receive_status_control_r[`AST_BIT_SERIAL_PORT_ON];
    wire ninth_tx_enable  = transmit_status_control_r[`AST_BIT_NINTH_TX_ENABLE];
    wire transmit_enable  = transmit_status_control_r[`AST_BIT_TRANSMIT_ENABLE];
    wire clocked_mode     = transmit_status_control_r[`AST_BIT_CLOCKED_MODE];
    wire high_speed_sel   = transmit_status_control_r[`AST_BIT_HIGH_SPEED_SELECT];
    wire ninth_bit_value  = transmit_status_control_r[`AST_BIT_NINTH_BIT_VALUE];
    wire shift_reg_empty  = (state_r == AST_IDLE);

    // Async only with clocked mode off, port on
    wire run = serial_port_on & ~clocked_mode & transmit_enable;  // see RULE5

    ////////////////////////////////////////////////////////////////////////////////
    // Holding buffer
    wire                buf_in_ready;
    wire                buf_out_valid;
    wire                buf_out_ready;
    ast_pkg::ast_word_t buf_out_data;
    wire                hold_write = reg_wr_i & sel_hold;

    ast_buf #(
        .W     (9),
        .DEPTH (2)
    ) i_ast_buf (
        .clock_i     (clock_i),
        .sys_rst_i   (sys_rst_i),
        .flush_i     (~transmit_enable),
        .in_valid_i  (hold_write),
        .in_ready_o  (buf_in_ready),
        .in_data_i   ({ninth_bit_value, reg_wdata_i}),  // see RULE8
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_out_ready),
        .out_data_o  (buf_out_data)
    );

    // Flag: enabled and buffer has room
    wire transmit_irq_flag = transmit_enable & buf_in_ready;  // see RULE9
    wire irq_nxt = core_irq_control_r[`AST_BIT_GLOBAL_IRQ_ENABLE] &
                   core_irq_control_r[`AST_BIT_PERIPH_IRQ_ENABLE] &
                   periph_irq_enables_r[`AST_BIT_TRANSMIT_IRQ] & transmit_irq_flag;  // see RULE6

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux
    logic [7:0] flags_view;
    logic [7:0] tsc_view;
    logic [7:0] rd_nxt;

    always_comb begin
        flags_view = 8'h00;
        flags_view[`AST_BIT_TRANSMIT_IRQ] = transmit_irq_flag;
        tsc_view = transmit_status_control_r & `AST_MASK_TRANSMIT_STATUS;
        tsc_view[`AST_BIT_SHIFT_REG_EMPTY] = shift_reg_empty;  // see RULE13
    end

    assign rd_nxt = sel_core  ? core_irq_control_r :
                    sel_flags ? flags_view :
                    sel_rcsc  ? receive_status_control_r :
                    sel_hold  ? transmit_holding_r :
                    sel_ien   ? periph_irq_enables_r :
                    sel_tsc   ? tsc_view :
                    sel_div   ? baud_divisor_r : 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            core_irq_control_r        <= `AST_RST_CORE_IRQ_CONTROL;
            periph_irq_enables_r      <= `AST_RST_PERIPH_IRQ_ENABLES;
            receive_status_control_r  <= `AST_RST_RECEIVE_STATUS_CTRL;
            transmit_status_control_r <= `AST_RST_TRANSMIT_STATUS_CTRL;
            baud_divisor_r            <= `AST_RST_BAUD_DIVISOR;
            transmit_holding_r        <= `AST_RST_TRANSMIT_HOLDING;
            reg_rdata_r               <= 8'h00;
            tx_irq_r                  <= 1'b0;
        end else begin
            if (reg_wr_i && sel_core) begin
                core_irq_control_r <= reg_wdata_i;
            end
            if (reg_wr_i && sel_ien) begin
                periph_irq_enables_r <= reg_wdata_i;
            end
            if (reg_wr_i && sel_rcsc) begin
                receive_status_control_r <= reg_wdata_i;
            end
            if (reg_wr_i && sel_tsc) begin
                transmit_status_control_r <= reg_wdata_i & `AST_MASK_TRANSMIT_STATUS;
            end
            if (reg_wr_i && sel_div) begin
                baud_divisor_r <= reg_wdata_i;
            end
            if (hold_write && transmit_irq_flag) begin
                transmit_holding_r <= reg_wdata_i;
            end
            if (reg_rd_i) begin
                reg_rdata_r <= rd_nxt;
            end
            tx_irq_r <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shifter
    wire                  bit_len_ld;
    ast_pkg::ast_bitlen_t bit_len;
    wire [10:0]           frame_word;

    assign bit_len       = ast_pkg::ast_bit_len(baud_divisor_r, high_speed_sel);  // see RULE2 RULE3 RULE4 RULE12
    assign buf_out_ready = run & (state_r == AST_IDLE);  // see RULE10
    assign bit_len_ld    = (timer_r == '0);
    // Start low, data LSB first, optional ninth, stop high
    assign frame_word    = ninth_tx_enable ? {1'b1, buf_out_data[8], buf_out_data[7:0], 1'b0}
                                           : {2'b11, buf_out_data[7:0], 1'b0};  // see RULE7 RULE13

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !run) begin
            state_r     <= AST_IDLE;
            timer_r     <= '0;
            shift_r     <= '1;
            bits_left_r <= '0;
            line_r      <= 1'b1;
        end else begin
            case (state_r)
                AST_IDLE: begin
                    if (buf_out_valid) begin
                        state_r     <= AST_SEND;
                        line_r      <= frame_word[0];
                        shift_r     <= {1'b1, frame_word[10:1]};
                        bits_left_r <= ast_pkg::ast_frame_bits(ninth_tx_enable) - 4'h1;
                        timer_r     <= bit_len - ast_pkg::ast_bitlen_t'(1);
                    end
                end
                AST_SEND: begin
                    if (!bit_len_ld) begin
                        timer_r <= timer_r - ast_pkg::ast_bitlen_t'(1);
                    end else if (bits_left_r == 4'h0) begin
                        state_r <= AST_IDLE;
                    end else begin
                        line_r      <= shift_r[0];
                        shift_r     <= {1'b1, shift_r[10:1]};
                        bits_left_r <= bits_left_r - 4'h1;
                        timer_r     <= bit_len - ast_pkg::ast_bitlen_t'(1);
                    end
                end
                default: state_r <= AST_IDLE;
            endcase
        end
    end

    assign reg_rdata_o  = reg_rdata_r;
    assign tx_irq_o     = tx_irq_r;
    assign link.tx_line = line_r;
endmodule

// File: hdl/ast_recv.sv
// Purpose: Remote asynchronous receiver at the far end of the serial line
// Assumes: Same clock and divisor as the transmitter
// Notes:   Samples each bit at its middle
`timescale 1ns/10ps

module ast_recv (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    // Setup
    input  wire logic [7:0] baud_divisor_i,
    input  wire logic       high_speed_select_i,
    input  wire logic       ninth_bit_enable_i,
    // Received word
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_ninth_o,
    output logic            rx_frame_err_o,
    // Serial line
    ast_if.recv             link
);
    typedef enum logic {AST_R_IDLE, AST_R_RECV} ast_rstate_t;

    logic                 sync1_r;
    logic                 sync2_r;
    logic                 prev_r;
    ast_rstate_t          state_r;
    ast_pkg::ast_bitlen_t timer_r;
    logic [10:0]          shift_r;
    logic [3:0]           left_r;
    logic                 valid_r;
    logic [7:0]           data_r;
    logic                 ninth_r;
    logic                 ferr_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Line synchroniser
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            prev_r  <= 1'b1;
        end else begin
            sync1_r <= link.tx_line;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame capture
    ast_pkg::ast_bitlen_t bit_len;
    wire                  start_edge = prev_r & ~sync2_r;
    wire [10:0]           shifted    = {sync2_r, shift_r[10:1]};

    assign bit_len = ast_pkg::ast_bit_len(baud_divisor_i, high_speed_select_i);  // see RULE12

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_r <= AST_R_IDLE;
            timer_r <= '0;
            shift_r <= '0;
            left_r  <= '0;
            valid_r <= 1'b0;
            data_r  <= 8'h00;
            ninth_r <= 1'b0;
            ferr_r  <= 1'b0;
        end else begin
            valid_r <= 1'b0;
            case (state_r)
                AST_R_IDLE: begin
                    if (start_edge) begin
                        state_r <= AST_R_RECV;
                        timer_r <= (bit_len >> 1) - ast_pkg::ast_bitlen_t'(1);
                        left_r  <= ast_pkg::ast_frame_bits(ninth_bit_enable_i);
                    end
                end
                AST_R_RECV: begin
                    if (timer_r != '0) begin
                        timer_r <= timer_r - ast_pkg::ast_bitlen_t'(1);
                    end else if (left_r == ast_pkg::ast_frame_bits(ninth_bit_enable_i) && sync2_r) begin
                        state_r <= AST_R_IDLE;
                    end else begin
                        shift_r <= shifted;
                        left_r  <= left_r - 4'h1;
                        timer_r <= bit_len - ast_pkg::ast_bitlen_t'(1);
                        if (left_r == 4'h1) begin
                            // Start low, LSB first, ninth, stop high
                            state_r <= AST_R_IDLE;
                            valid_r <= 1'b1;
                            data_r  <= ninth_bit_enable_i ? shifted[8:1] : shifted[9:2];  // see RULE7 RULE13
                            ninth_r <= ninth_bit_enable_i & shifted[9];
                            ferr_r  <= ~shifted[10];
                        end
                    end
                end
                default: state_r <= AST_R_IDLE;
            endcase
        end
    end

    assign rx_valid_o     = valid_r;
    assign rx_data_o      = data_r;
    assign rx_ninth_o     = ninth_r;
    assign rx_frame_err_o = ferr_r;
endmodule

// File: testbench/ast_monitor.sv
// Purpose: Checks on the serial line, receiver and interrupt
// Assumes: Receiver setup matches the transmitter
// Notes:   Stopping the transmitter masks frame checks until idle
`timescale 1ns/10ps

module ast_monitor (
    // Clock and reset
    input wire logic       clock_i,
    input wire logic       sys_rst_i,
    // Register writes and interrupt
    input wire logic [8:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       tx_irq_o,
    // Serial line and receiver
    input wire logic       tx_line,
    input wire logic [7:0] baud_divisor_i,
    input wire logic       high_speed_select_i,
    input wire logic       rx_valid_o,
    input wire logic       rx_frame_err_o
);

    ////////////////////////////////////////////////////////////////////////////////
    wire logic [19:0] bit_len = ({12'h000, baud_divisor_i} + 20'h00001) << (high_speed_select_i ? 4 : 6);
    wire logic        wr_core = reg_wr_i && (reg_addr_i[6:0] == 7'h0B);
    wire logic        wr_pie  = reg_wr_i && (reg_addr_i == 9'h08C);
    wire logic        wr_tsc  = reg_wr_i && (reg_addr_i == 9'h098);
    wire logic        wr_rcs  = reg_wr_i && (reg_addr_i == 9'h018);
    wire logic        stop_wr = (wr_tsc && !reg_wdata_i[5]) || (wr_rcs && !reg_wdata_i[7]);
    logic [19:0]      low_r;
    logic [19:0]      high_r;
    logic             dirty_r;
    logic [1:0]       core_r;
    logic             transmit_irq_enable_r;
    logic [7:0]       tsc_r;
    logic             on_r;
    wire logic        en_all  = (core_r == 2'b11) && transmit_irq_enable_r;
    wire logic        run     = on_r && tsc_r[5] && !tsc_r[4];

    // Line run lengths, register shadows
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            low_r   <= '0;
            high_r  <= '0;
            dirty_r <= 1'b0;
            core_r  <= 2'b00;
            transmit_irq_enable_r  <= 1'b0;
            tsc_r   <= 8'h00;
            on_r    <= 1'b0;
        end else begin
            low_r   <= tx_line ? 20'h00000 : low_r + 20'h00001;
            high_r  <= tx_line ? high_r + 20'h00001 : 20'h00000;
            dirty_r <= stop_wr || (dirty_r && (high_r < bit_len * 20'h0000C));
            core_r  <= wr_core ? reg_wdata_i[7:6] : core_r;
            transmit_irq_enable_r  <= wr_pie ? reg_wdata_i[4] : transmit_irq_enable_r;
            tsc_r   <= wr_tsc ? reg_wdata_i : tsc_r;
            on_r    <= wr_rcs ? reg_wdata_i[7] : on_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    property p_rst_idle;
        $fell(sys_rst_i) |-> tx_line && !tx_irq_o && !rx_valid_o;
    endproperty
    property p_bit_len;
        $rose(tx_line) && !dirty_r |-> (low_r != 0) && ((low_r % bit_len) == 0);
    endproperty
    property p_pulse;
        rx_valid_o |=> !rx_valid_o;
    endproperty
    property p_stop_bit;
        rx_valid_o && !dirty_r |-> !rx_frame_err_o && $past(tx_line, 4);
    endproperty
    property p_irq_gate;
        tx_irq_o |-> $past(en_all);
    endproperty
    property p_irq_drop;
        $fell(en_all) |=> !tx_irq_o;
    endproperty
    property p_irq_rise;
        wr_tsc && reg_wdata_i[5] && !tsc_r[5] && en_all |-> ##[2:3] tx_irq_o;
    endproperty
    property p_start_gate;
        $fell(tx_line) |-> $past(run);
    endproperty

    a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
    a_bit_len: assert property (p_bit_len) else $error("low run not whole bits");
    a_pulse: assert property (p_pulse) else $error("word pulse too long");
    a_stop_bit: assert property (p_stop_bit) else $error("stop bit not high");
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");
    a_irq_drop: assert property (p_irq_drop) else $error("irq stays after disable");
    a_irq_rise: assert property (p_irq_rise) else $error("enable did not raise flag");
    a_start_gate: assert property (p_start_gate) else $error("frame while not running");

    c_frame: cover property (rx_valid_o && !rx_frame_err_o);
    c_fast: cover property (rx_valid_o && high_speed_select_i);
    c_irq: cover property ($rose(tx_irq_o));

endmodule

// File: testbench/ast_tb_top.sv
// Purpose: Self-checking bench joining transmitter and receiver over the link
// Assumes: Divisor 0, high speed: 16-clock bits
// Notes:   Bit rates are judged against a 20 MHz oscillator
`timescale 1ns/10ps

module ast_tb_top;
    logic       clock_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [8:0] reg_addr_i = 9'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic       tx_irq_o;
    logic [7:0] rx_div = 8'h00;
    logic       rx_fast = 1'b1;
    logic       rx_nine = 1'b0;
    logic       rx_valid_o;
    logic [7:0] rx_data_o;
    logic       rx_ninth_o;
    logic       rx_frame_err_o;
    int         bad_count = 0;
    int         compares = 0;
    int         cycles = 0;

    ast_if i_ast_if ();
    ast_xmit i_ast_xmit (.clock_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .tx_irq_o, .link(i_ast_if.xmit));
    ast_recv i_ast_recv (.clock_i, .sys_rst_i, .baud_divisor_i(rx_div), .high_speed_select_i(rx_fast),
        .ninth_bit_enable_i(rx_nine), .rx_valid_o, .rx_data_o, .rx_ninth_o, .rx_frame_err_o, .link(i_ast_if.recv));
    ast_monitor i_ast_monitor (.clock_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .tx_irq_o,
        .tx_line(i_ast_if.tx_line), .baud_divisor_i(rx_div), .high_speed_select_i(rx_fast), .rx_valid_o,
        .rx_frame_err_o);

    always #20 clock_i = ~clock_i;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clock_i) #1;
        reg_addr_i  = a;
        reg_wdata_i = d;
        reg_wr_i    = 1'b1;
        @(posedge clock_i) #1;
        reg_wr_i = 1'b0;
    endtask

    task automatic rdc(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clock_i) #1;
        reg_addr_i = a;
        reg_rd_i   = 1'b1;
        @(posedge clock_i) #1;
        reg_rd_i = 1'b0;
        chk($sformatf("reg %h", a), reg_rdata_o, exp);
    endtask

    task automatic cfg(input logic [7:0] div, input logic [7:0] tsc);
        rx_div  = div;
        rx_fast = tsc[2];
        rx_nine = tsc[6];
        wr(9'h099, div);
        wr(9'h018, 8'h80);
        wr(9'h098, tsc);
    endtask

    // Next received word: error, ninth bit, byte
    task automatic exp_rx(input logic [7:0] d, input logic nine);
        int n;
        @(posedge clock_i) #1;
        for (n = 0; n < 4000 && rx_valid_o !== 1'b1; n++)
            @(posedge clock_i) #1;
        chk("rx word", {rx_frame_err_o, rx_ninth_o, rx_data_o}, {1'b0, nine, d});
    endtask

    task automatic quiet(input int n);
        int seen = 0;
        repeat (n) begin
            @(posedge clock_i) #1;
            if (rx_valid_o !== 1'b0 || i_ast_if.tx_line !== 1'b1)
                seen++;
        end
        chk("line quiet", seen, 0);
    endtask

    task automatic irqc(input logic exp);
        repeat (3) @(posedge clock_i) #1;
        chk("irq", tx_irq_o, exp);
    endtask

    task automatic rst;
        @(posedge clock_i) #1;
        sys_rst_i = 1'b1;
        repeat (4) @(posedge clock_i);
        #1;
        sys_rst_i = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdc(9'h098, 8'h02);
        rdc(9'h00C, 8'h00);
        rdc(9'h099, 8'h00);
        rdc(9'h08C, 8'h00);
        wr(9'h1FF, 8'h5A);
        rdc(9'h1FF, 8'h00);
        wr(9'h00C, 8'hFF);
        rdc(9'h00C, 8'h00);
    endtask

    // Start bit of an all-ones byte gives the rate
    task automatic t_baud;
        logic [7:0] divs [4] = '{8'h81, 8'h20, 8'h81, 8'h04};
        int         bauds [4] = '{2404, 9470, 9615, 250000};
        int         n;
        int         k;
        for (int i = 0; i < 4; i++) begin
            cfg(divs[i], (i > 1) ? 8'h24 : 8'h20);
            wr(9'h019, 8'hFF);
            n = 0;
            for (k = 0; k < 20 && i_ast_if.tx_line !== 1'b0; k++)
                @(posedge clock_i) #1;
            while (i_ast_if.tx_line === 1'b0 && n < 20000) begin
                n++;
                @(posedge clock_i) #1;
            end
            chk("baud", (20000000 + n / 2) / (n + (n == 0)), bauds[i]);
            wr(9'h098, 8'h00);
            rst();
        end
    endtask

    task automatic t_frames;
        cfg(8'h00, 8'h24);
        rdc(9'h00C, 8'h10);
        wr(9'h019, 8'hA5);
        wr(9'h019, 8'h3C);
        wr(9'h019, 8'h81);
        rdc(9'h00C, 8'h00);
        wr(9'h019, 8'h7E);
        rdc(9'h098, 8'h24);
        rdc(9'h019, 8'h81);
        exp_rx(8'hA5, 1'b0);
        exp_rx(8'h3C, 1'b0);
        exp_rx(8'h81, 1'b0);
        quiet(200);
        rdc(9'h098, 8'h26);
        cfg(8'h00, 8'h65);
        wr(9'h019, 8'h5A);
        exp_rx(8'h5A, 1'b1);
        wr(9'h098, 8'h64);
        wr(9'h019, 8'hC3);
        exp_rx(8'hC3, 1'b0);
    endtask

    task automatic t_irq;
        wr(9'h00B, 8'hC0);
        wr(9'h08C, 8'h10);
        irqc(1'b1);
        wr(9'h08C, 8'h00);
        irqc(1'b0);
        wr(9'h08C, 8'h10);
        wr(9'h18B, 8'h40);
        irqc(1'b0);
        wr(9'h08B, 8'hC0);
        irqc(1'b1);
        wr(9'h098, 8'h04);
        wr(9'h019, 8'h11);
        irqc(1'b0);
        quiet(200);
        wr(9'h098, 8'h24);
        irqc(1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            complete_run();
        end
    end

    initial begin
        repeat (4) @(posedge clock_i);
        #1;
        sys_rst_i = 1'b0;
        t_reset();
        t_baud();
        t_frames();
        t_irq();
        complete_run();
    end
endmodule
